// ### design/dat_tx.sv
/*
  Digital audio transmitter control: register file, two ping-pong
  buffer fetch, staging, serialiser for subframe and raw word formats.
  Assumes a memory port answering one request at a time and a
  processor-only reset input synchronous to CLK.
*/
// Notes on behaviour
// - buffer one drained flag sticks until acked
// - buffer two drained flag sticks until acked
// - fetch error flag when staging runs dry
// - both drained: underrun flag, still switch
// - in-use bit high for buffer one
// - ack bits read zero, one clears
// - interrupt when any flag and enable
// - stay awake bit blocks power down
// - byte order bit picks word assembly
// - format 000 sends subframes with coding
// - 010 raw lsb first, 011 msb first
// - run starts; clearing halts after word
// - self reset bit resets all but time counter
// - start and length writes keep flags
// - one length, two start addresses
// - departure time of last drained buffer
// - reset values zero, in-use bit one
// - reset by pin or self reset only
// - time counter cleared by processor reset
// - flag drops cycle after ack write
// - buffers alternate one, two, one
// - frame is 128 unit intervals
`timescale 1ns/1ps
`default_nettype none

module dat_tx #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CPU_RST,
  input wire logic GLOBAL_POWER_DOWN,
  input wire logic [3:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  output logic MEM_REQ,
  output logic [31:0] MEM_ADDR,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA,
  output logic AUDIO_OUT,
  output logic IRQ,
  output logic POWERED_DOWN
);

  typedef struct packed {
    logic [31:0] rate;
    logic [31:0] phase;
    logic [31:0] first_start;
    logic [31:0] second_start;
    logic [31:0] length;
    logic [31:0] depart;
    logic [31:0] ts_cnt;
    logic [3:0] flags;
    logic in_use1;
    logic [3:0] irq_en;
    logic stay_awake;
    logic little_endian;
    logic [2:0] fmt;
    logic run;
    dat_pkg::dat_state_t state;
    logic req;
    logic [31:0] req_addr;
    logic fetch_second;
    logic [31:0] fetch_off;
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic rd_pending;
    logic hold_valid;
    logic [31:0] hold_word;
    logic [31:0] shift;
    logic [5:0] ui_cnt;
    logic sub_lvl;
    logic [8:0] sub_cnt;
    logic [31:0] tx_off;
    logic [31:0] rdata;
    logic out;
  } dat_state_all_t;

  localparam dat_state_all_t RESET_VAL = '{
    in_use1: 1'b1, state: dat_pkg::DAT_IDLE, default: '0};

  dat_state_all_t r_reg;
  dat_state_all_t r_next;

  logic [32:0] phase_sum;
  logic tick;
  logic asleep;
  logic wr_ctl;
  logic [3:0] clr;
  logic [3:0] set;
  logic rd_en;
  logic [AW:0] fill;
  logic [31:0] mem_word;
  logic [31:0] stage_dout;
  logic iec;
  logic [4:0] slot;
  logic [7:0] pre;
  logic bit_val;
  logic word_last;
  logic buf_done;
  logic [31:0] ts_keep;
  logic [31:0] next_off;

  dat_stage_mem #(.W(32), .DEPTH(DEPTH), .AW(AW)) u_stage (
    .clk(CLK),
    .rstn(RSTN),
    .wr_en(r_reg.req & MEM_ACK),
    .wr_addr(r_reg.wptr[AW-1:0]),
    .wr_data(mem_word),
    .rd_en(rd_en),
    .rd_addr(r_reg.rptr[AW-1:0]),
    .rd_data(stage_dout)
  );

  // memory lanes carry the byte at the lowest address in bits 7:0
  assign mem_word = r_reg.little_endian ? MEM_RDATA :
    {MEM_RDATA[7:0], MEM_RDATA[15:8], MEM_RDATA[23:16], MEM_RDATA[31:24]};

  always_comb begin
    r_next = r_reg;
    rd_en = 1'b0;
    set = 4'h0;
    ts_keep = '0;
    next_off = '0;
    asleep = GLOBAL_POWER_DOWN & ~r_reg.stay_awake;
    wr_ctl = REG_WR && (REG_ADDR == dat_pkg::REG_CONTROL);
    clr = wr_ctl ? REG_WDATA[dat_pkg::CT_ACK_LSB +: dat_pkg::FLG_COUNT] : 4'h0;
    fill = r_reg.wptr - r_reg.rptr;
    phase_sum = {1'b0, r_reg.phase} + {1'b0, r_reg.rate};
    tick = phase_sum[32];
    iec = (r_reg.fmt == dat_pkg::FMT_IEC);
    slot = r_reg.ui_cnt[5:1];
    word_last = iec ? (r_reg.ui_cnt == dat_pkg::UI_LAST_IEC) :
      (r_reg.ui_cnt[4:0] == dat_pkg::UI_LAST_RAW);
    buf_done = (r_reg.tx_off + dat_pkg::BYTES_PER_WORD) >= r_reg.length;
    pre = (r_reg.sub_cnt == 9'h000) ? dat_pkg::PRE_BLOCK :
      (r_reg.sub_cnt[0] ? dat_pkg::PRE_RIGHT : dat_pkg::PRE_LEFT);
    if (iec) begin
      bit_val = (slot == dat_pkg::SLOT_PARITY) ?
        ^r_reg.shift[30:dat_pkg::SLOT_FIRST_DATA] : r_reg.shift[slot];
    end else if (r_reg.fmt == dat_pkg::FMT_MSB_FIRST) begin
      bit_val = r_reg.shift[~r_reg.ui_cnt[4:0]];
    end else begin
      bit_val = r_reg.shift[r_reg.ui_cnt[4:0]];
    end

    // time counter follows the processor cycle counter
    r_next.ts_cnt = CPU_RST ? '0 : r_reg.ts_cnt + 32'h1;

    if (REG_WR) begin
      case (REG_ADDR)
        dat_pkg::REG_CONTROL: begin
          r_next.irq_en = REG_WDATA[dat_pkg::CT_IRQ_EN_LSB +: dat_pkg::FLG_COUNT];
          r_next.stay_awake = REG_WDATA[dat_pkg::CT_STAY_AWAKE];
          r_next.little_endian = REG_WDATA[dat_pkg::CT_LITTLE_END];
          r_next.fmt = REG_WDATA[dat_pkg::CT_FMT_LSB +: 3];
          r_next.run = REG_WDATA[dat_pkg::CT_RUN];
        end
        dat_pkg::REG_SYNTH_RATE: r_next.rate = REG_WDATA;
        // start and length writes never touch the flags
        dat_pkg::REG_FIRST_START: r_next.first_start = REG_WDATA;
        dat_pkg::REG_SECOND_START: r_next.second_start = REG_WDATA;
        dat_pkg::REG_BUFFER_LENGTH: r_next.length = REG_WDATA;
        default: begin
        end
      endcase
    end

    if (!asleep) begin
      r_next.phase = phase_sum[31:0];
      // fetch side: one request in flight, only while room remains
      if (r_reg.req) begin
        if (MEM_ACK) begin
          r_next.req = 1'b0;
          r_next.wptr = r_reg.wptr + 1'b1;
          next_off = r_reg.fetch_off + dat_pkg::BYTES_PER_WORD;
          if (next_off >= r_reg.length) begin
            r_next.fetch_off = '0;
            r_next.fetch_second = ~r_reg.fetch_second;
          end else begin
            r_next.fetch_off = next_off;
          end
        end
      end else if (r_reg.run && (r_reg.length != '0) && (fill < (AW+1)'(DEPTH))) begin
        r_next.req = 1'b1;
        r_next.req_addr = (r_reg.fetch_second ? r_reg.second_start : r_reg.first_start)
          + r_reg.fetch_off;
      end
      // holding register refill from the staging memory
      if (r_reg.rd_pending) begin
        r_next.rd_pending = 1'b0;
        r_next.hold_valid = 1'b1;
        r_next.hold_word = stage_dout;
      end else if (!r_reg.hold_valid && (fill != '0)) begin
        rd_en = 1'b1;
        r_next.rptr = r_reg.rptr + 1'b1;
        r_next.rd_pending = 1'b1;
      end

      case (r_reg.state)
        dat_pkg::DAT_IDLE: begin
          if (r_reg.run && r_reg.hold_valid) begin
            r_next.shift = r_reg.hold_word;
            r_next.hold_valid = 1'b0;
            r_next.ui_cnt = '0;
            r_next.sub_lvl = r_reg.out;
            r_next.state = dat_pkg::DAT_SEND;
          end
        end
        dat_pkg::DAT_SEND: begin
          if (tick) begin
            r_next.ui_cnt = r_reg.ui_cnt + 6'h01;
            if (!iec) begin
              r_next.out = bit_val;
            end else if (slot < dat_pkg::SLOT_FIRST_DATA) begin
              r_next.out = pre[~r_reg.ui_cnt[2:0]] ^ r_reg.sub_lvl;
            end else if (!r_reg.ui_cnt[0]) begin
              r_next.out = ~r_reg.out;
            end else begin
              r_next.out = bit_val ? ~r_reg.out : r_reg.out;
            end
            if (word_last) begin
              r_next.ui_cnt = '0;
              if (iec) begin
                r_next.sub_cnt = (r_reg.sub_cnt == dat_pkg::SUBFRAMES_PER_BLOCK - 9'h001) ?
                  '0 : r_reg.sub_cnt + 9'h001;
              end
              r_next.tx_off = r_reg.tx_off + dat_pkg::BYTES_PER_WORD;
              if (buf_done) begin
                r_next.tx_off = '0;
                set[r_reg.in_use1 ? dat_pkg::FLG_FIRST : dat_pkg::FLG_SECOND] = 1'b1;
                r_next.depart = r_reg.ts_cnt;
                r_next.in_use1 = ~r_reg.in_use1;
                // an un-acked other buffer means both ran dry; data goes out stale
                if (r_reg.in_use1 ? r_reg.flags[dat_pkg::FLG_SECOND] :
                    r_reg.flags[dat_pkg::FLG_FIRST]) begin
                  set[dat_pkg::FLG_UNDER] = 1'b1;
                end
              end
              if (!r_reg.run) begin
                r_next.state = dat_pkg::DAT_IDLE;
              end else if (r_reg.hold_valid) begin
                r_next.shift = r_reg.hold_word;
                r_next.hold_valid = 1'b0;
                r_next.sub_lvl = r_next.out;
              end else begin
                // staging ran dry: word repeats, its slot is lost
                set[dat_pkg::FLG_FETCH] = 1'b1;
                r_next.sub_lvl = r_next.out;
              end
            end
          end
        end
        default: r_next.state = dat_pkg::DAT_IDLE;
      endcase
    end

    // hardware set wins over a same-cycle acknowledge
    r_next.flags = (r_reg.flags & ~clr) | set;

    if (REG_RD) begin
      case (REG_ADDR)
        dat_pkg::REG_STATUS: r_next.rdata = 32'({r_reg.in_use1, r_reg.flags});
        dat_pkg::REG_CONTROL: r_next.rdata = 32'({r_reg.run, r_reg.fmt, r_reg.little_endian,
          r_reg.stay_awake, r_reg.irq_en, 4'h0});
        dat_pkg::REG_SYNTH_RATE: r_next.rdata = r_reg.rate;
        dat_pkg::REG_FIRST_START: r_next.rdata = r_reg.first_start;
        dat_pkg::REG_SECOND_START: r_next.rdata = r_reg.second_start;
        dat_pkg::REG_BUFFER_LENGTH: r_next.rdata = r_reg.length;
        dat_pkg::REG_DEPARTURE_TIME: r_next.rdata = r_reg.depart;
        default: r_next.rdata = '0;
      endcase
    end

    // self reset spares only the time counter
    if (wr_ctl && REG_WDATA[dat_pkg::CT_SELF_RESET]) begin
      ts_keep = r_next.ts_cnt;
      r_next = RESET_VAL;
      r_next.ts_cnt = ts_keep;
    end
  end

  // processor-only reset deliberately reaches nothing but the time counter
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      r_reg <= RESET_VAL;
    end else begin
      r_reg <= r_next;
    end
  end

  assign REG_RDATA = r_reg.rdata;
  assign MEM_REQ = r_reg.req;
  assign MEM_ADDR = r_reg.req_addr;
  assign AUDIO_OUT = r_reg.out;
  assign IRQ = |(r_reg.flags & r_reg.irq_en);
  assign POWERED_DOWN = asleep;

  property p_first_sticky;
    @(posedge CLK) disable iff (!RSTN)
    r_reg.flags[dat_pkg::FLG_FIRST] && !clr[dat_pkg::FLG_FIRST] && !(wr_ctl &&
      REG_WDATA[dat_pkg::CT_SELF_RESET]) |=> r_reg.flags[dat_pkg::FLG_FIRST];
  endproperty
  a_first_sticky: assert property (p_first_sticky)
    else $error("first drained flag dropped without ack");

  property p_ack_drops;
    @(posedge CLK) disable iff (!RSTN)
    r_reg.flags[dat_pkg::FLG_SECOND] && clr[dat_pkg::FLG_SECOND] &&
      !set[dat_pkg::FLG_SECOND] |=> !r_reg.flags[dat_pkg::FLG_SECOND];
  endproperty
  a_ack_drops: assert property (p_ack_drops)
    else $error("second drained flag not cleared after ack");

  property p_irq_follows;
    @(posedge CLK) disable iff (!RSTN)
    $rose(r_reg.flags[dat_pkg::FLG_FETCH]) && r_reg.irq_en[dat_pkg::FLG_FETCH] |-> IRQ;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("interrupt missing for enabled fetch error");

  property p_length_keeps_flags;
    @(posedge CLK) disable iff (!RSTN)
    REG_WR && (REG_ADDR == dat_pkg::REG_BUFFER_LENGTH) && (set == 4'h0)
      |=> r_reg.flags == $past(r_reg.flags);
  endproperty
  a_length_keeps_flags: assert property (p_length_keeps_flags)
    else $error("length write changed status flags");

  property p_stamp_with_flag;
    @(posedge CLK) disable iff (!RSTN)
    set[dat_pkg::FLG_FIRST] && !(wr_ctl && REG_WDATA[dat_pkg::CT_SELF_RESET])
      |=> r_reg.flags[dat_pkg::FLG_FIRST] &&
      (r_reg.depart == $past(r_reg.ts_cnt));
  endproperty
  a_stamp_with_flag: assert property (p_stamp_with_flag)
    else $error("departure time not loaded with drained flag");

  property p_switch_buffer;
    @(posedge CLK) disable iff (!RSTN)
    set[dat_pkg::FLG_FIRST] && !(wr_ctl && REG_WDATA[dat_pkg::CT_SELF_RESET])
      |=> !r_reg.in_use1;
  endproperty
  a_switch_buffer: assert property (p_switch_buffer)
    else $error("no switch to second buffer");

  property p_underrun;
    @(posedge CLK) disable iff (!RSTN)
    set[dat_pkg::FLG_FIRST] && r_reg.flags[dat_pkg::FLG_SECOND] &&
      !(wr_ctl && REG_WDATA[dat_pkg::CT_SELF_RESET]) |=> r_reg.flags[dat_pkg::FLG_UNDER];
  endproperty
  a_underrun: assert property (p_underrun)
    else $error("underrun not flagged");

  property p_self_reset;
    @(posedge CLK) disable iff (!RSTN)
    wr_ctl && REG_WDATA[dat_pkg::CT_SELF_RESET] |=> (r_reg.flags == 4'h0) &&
      r_reg.in_use1 && !r_reg.run && (r_reg.state == dat_pkg::DAT_IDLE);
  endproperty
  a_self_reset: assert property (p_self_reset)
    else $error("self reset did not restore reset state");

  property p_halt_after_word;
    @(posedge CLK) disable iff (!RSTN)
    (r_reg.state == dat_pkg::DAT_SEND) && !(tick && word_last) && !asleep &&
      !(wr_ctl && REG_WDATA[dat_pkg::CT_SELF_RESET]) |=> r_reg.state == dat_pkg::DAT_SEND;
  endproperty
  a_halt_after_word: assert property (p_halt_after_word)
    else $error("transmission left before word end");

  property p_ack_reads_zero;
    @(posedge CLK) disable iff (!RSTN)
    REG_RD && (REG_ADDR == dat_pkg::REG_CONTROL) |=> REG_RDATA[3:0] == 4'h0;
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero)
    else $error("ack bits read back nonzero");

endmodule

`default_nettype wire

// ### shared/dat_pkg.sv
/*
  Shared constants of the digital audio transmitter: register indices,
  field positions, format codes, state codes and framing.
  Assumes a word-wide register port indexed by register number.
*/
package dat_pkg;

  // register indices on the register port
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h1;
  localparam logic [3:0] REG_SYNTH_RATE = 4'h2;
  localparam logic [3:0] REG_FIRST_START = 4'h3;
  localparam logic [3:0] REG_SECOND_START = 4'h4;
  localparam logic [3:0] REG_BUFFER_LENGTH = 4'h5;
  localparam logic [3:0] REG_DEPARTURE_TIME = 4'h6;

  // sticky flag positions, same in status and in the ack/enable groups
  localparam int FLG_FIRST = 0;
  localparam int FLG_SECOND = 1;
  localparam int FLG_FETCH = 2;
  localparam int FLG_UNDER = 3;
  localparam int FLG_COUNT = 4;

  // status fields
  localparam int ST_IN_USE_BIT = 4;

  // control fields
  localparam int CT_ACK_LSB = 0;
  localparam int CT_IRQ_EN_LSB = 4;
  localparam int CT_STAY_AWAKE = 8;
  localparam int CT_LITTLE_END = 9;
  localparam int CT_FMT_LSB = 10;
  localparam int CT_RUN = 13;
  localparam int CT_SELF_RESET = 14;

  // format select codes
  localparam logic [2:0] FMT_IEC = 3'h0;
  localparam logic [2:0] FMT_LSB_FIRST = 3'h2;
  localparam logic [2:0] FMT_MSB_FIRST = 3'h3;

  // framing: 32 slots of two unit intervals per subframe, two per frame
  localparam int UI_PER_FRAME = 128;
  localparam logic [5:0] UI_LAST_IEC = 6'(UI_PER_FRAME / 2 - 1);
  localparam logic [4:0] UI_LAST_RAW = 5'h1F;
  localparam logic [4:0] SLOT_PARITY = 5'h1F;
  localparam logic [4:0] SLOT_FIRST_DATA = 5'h04;
  localparam logic [8:0] SUBFRAMES_PER_BLOCK = 9'h180;
  localparam logic [7:0] PRE_BLOCK = 8'hE8;
  localparam logic [7:0] PRE_LEFT = 8'hE2;
  localparam logic [7:0] PRE_RIGHT = 8'hE4;
  localparam logic [31:0] BYTES_PER_WORD = 32'h4;

  // transmit states
  typedef enum logic [1:0] {
    DAT_IDLE = 2'b01,
    DAT_SEND = 2'b10
  } dat_state_t;

endpackage

// ### design/dat_stage_mem.sv
/*
  Staging memory for fetched words: one write port, one read port,
  read data registered. Assumes the caller keeps pointers and counts.
*/
`timescale 1ns/1ps
`default_nettype none

module dat_stage_mem #(
  parameter int W = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] dout;
  } dat_mem_state_t;

  dat_mem_state_t r_reg;
  dat_mem_state_t r_next;

  always_comb begin
    r_next = r_reg;
    if (wr_en) begin
      r_next.mem[wr_addr] = wr_data;
    end
    if (rd_en) begin
      r_next.dout = r_reg.mem[rd_addr];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rd_data = r_reg.dout;

endmodule

`default_nettype wire

// ### bench/dat_mem_model.sv
/*
  Memory partner for the transmitter fetch port: answers each request
  with one acknowledge cycle, promptly or three cycles late.
  Assumes one outstanding request, request held until acknowledge.
*/
`timescale 1ns/1ps
`default_nettype none

module dat_mem_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [1:0] wait_cnt;

  // odd word addresses answer late, so both timings get exercised
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_ack <= 1'h0;
      wait_cnt <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_ack) begin
      // request still high in this cycle; it is not a new one
      mem_ack <= 1'h0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && wait_cnt == (mem_addr[2] ? 2'h3 : 2'h0)) begin
      mem_ack <= 1'h1;
      wait_cnt <= 2'h0;
      mem_rdata <= mem_addr ^ 32'hA5A5A5A5;
    end else begin
      wait_cnt <= mem_req ? wait_cnt + 2'h1 : 2'h0;
      // data outside the answer cycle keeps changing, never looks valid
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

`default_nettype wire

// ### bench/dat_tx_tb_top.sv
/*
  Self-checking bench of the transmitter: registers, buffer ping-pong,
  sticky flags, interrupt, resets, halt, power-down, subframe coding.
  Assumes the memory partner and a 125 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dat_tx_tb_top;
  logic CLK = 1'h0;
  logic RSTN = 1'h0;
  logic CPU_RST = 1'h0;
  logic GLOBAL_POWER_DOWN = 1'h0;
  logic [3:0] REG_ADDR = 4'h0;
  logic REG_WR = 1'h0;
  logic REG_RD = 1'h0;
  logic [31:0] REG_WDATA = 32'h0;
  logic [31:0] REG_RDATA, MEM_ADDR, MEM_RDATA;
  logic MEM_REQ, MEM_ACK, AUDIO_OUT, IRQ, POWERED_DOWN;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] rd;

  always #4 CLK = ~CLK;

  // free cycle count, so time stamps can be bounded without peeking inside
  always @(posedge CLK) cycles <= cycles + 1;

  dat_tx dut_u (.CLK(CLK), .RSTN(RSTN), .CPU_RST(CPU_RST),
    .GLOBAL_POWER_DOWN(GLOBAL_POWER_DOWN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .MEM_REQ(MEM_REQ),
    .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .AUDIO_OUT(AUDIO_OUT),
    .IRQ(IRQ), .POWERED_DOWN(POWERED_DOWN));

  dat_mem_model mem_u (.clk(CLK), .rstn(RSTN), .mem_req(MEM_REQ), .mem_addr(MEM_ADDR),
    .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'h1;
    @(posedge CLK);
    REG_WR <= 1'h0;
  endtask

  task automatic reg_rd(input logic [3:0] a);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'h1;
    @(posedge CLK);
    REG_RD <= 1'h0;
    @(posedge CLK);
    #1 rd = REG_RDATA;
  endtask

  // raw lsb-first run word; software keeps undefined bits at zero
  function automatic logic [31:0] ctl(input logic run, input logic [3:0] en,
                                      input logic [3:0] ack);
    return (32'(run) << dat_pkg::CT_RUN) | (32'(dat_pkg::FMT_LSB_FIRST) << dat_pkg::CT_FMT_LSB)
      | (32'h1 << dat_pkg::CT_LITTLE_END) | (32'(en) << dat_pkg::CT_IRQ_EN_LSB) | 32'(ack);
  endfunction

  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && IRQ !== 1'h1; i++) @(posedge CLK);
    check(32'(IRQ), 32'h1, "irq raised");
  endtask

  task automatic t_reset_values;
    reg_rd(dat_pkg::REG_STATUS);
    check(rd, 32'h10, "status after reset");
    for (int i = 1; i < 7; i++) begin
      reg_rd(4'(i));
      check(rd, 32'h0, "register after reset");
    end
    reg_rd(4'hF);
    check(rd, 32'h0, "unmapped read");
  endtask

  task automatic t_setup;
    reg_wr(dat_pkg::REG_SYNTH_RATE, 32'h80000000);
    reg_wr(dat_pkg::REG_FIRST_START, 32'h1000);
    reg_wr(dat_pkg::REG_SECOND_START, 32'h2000);
    reg_wr(dat_pkg::REG_BUFFER_LENGTH, 32'h40);
    reg_rd(dat_pkg::REG_SECOND_START);
    check(rd, 32'h2000, "second start");
    reg_rd(dat_pkg::REG_BUFFER_LENGTH);
    check(rd, 32'h40, "length");
    reg_rd(dat_pkg::REG_STATUS);
    check(rd, 32'h10, "status after start writes");
    reg_wr(dat_pkg::REG_CONTROL, ctl(1'h0, 4'h1, 4'hF));
    reg_rd(dat_pkg::REG_CONTROL);
    check(rd, ctl(1'h0, 4'h1, 4'h0), "acks read zero");
  endtask

  task automatic t_first_drain;
    reg_wr(dat_pkg::REG_CONTROL, ctl(1'h1, 4'h1, 4'h0));
    // look after the edge has settled; only the first look, before any wait, falls in the launching time step
    for (int i = 0; i < 20 && MEM_REQ !== 1'h1; i++) begin
      @(posedge CLK);
      #1;
    end
    check(MEM_ADDR, 32'h1000, "first fetch address");
    wait_irq(3000);
    reg_rd(dat_pkg::REG_STATUS);
    check(rd, 32'h01, "first drained, second in use");
    reg_rd(dat_pkg::REG_DEPARTURE_TIME);
    check(32'(rd != 32'h0), 32'h1, "departure time loaded");
    reg_wr(dat_pkg::REG_CONTROL, ctl(1'h1, 4'h1, 4'h1));
    @(posedge CLK);
    #1 check(32'(IRQ), 32'h0, "irq after ack");
    reg_rd(dat_pkg::REG_STATUS);
    check(rd, 32'h00, "flag cleared by ack");
  endtask

  task automatic t_underrun;
    // second buffer is never acknowledged, so buffer one's next drain underruns
    reg_wr(dat_pkg::REG_CONTROL, ctl(1'h1, 4'h8, 4'h0));
    wait_irq(5000);
    reg_rd(dat_pkg::REG_STATUS);
    check(rd, 32'h0B, "underrun, switched anyway");
    reg_wr(dat_pkg::REG_CONTROL, ctl(1'h1, 4'h8, 4'h8));
    @(posedge CLK);
    #1 check(32'(IRQ), 32'h0, "irq after underrun ack");
    reg_wr(dat_pkg::REG_FIRST_START, 32'h3000);
    reg_rd(dat_pkg::REG_STATUS);
    check(rd, 32'h03, "only underrun cleared");
  endtask

  task automatic t_halt;
    int reqs;
    int flips;
    logic last;
    reqs = 0;
    flips = 0;
    reg_wr(dat_pkg::REG_CONTROL, ctl(1'h0, 4'h0, 4'h0));
    repeat (100) @(posedge CLK);
    last = AUDIO_OUT;
    repeat (200) begin
      @(posedge CLK);
      if (MEM_REQ !== 1'h0) reqs++;
      if (AUDIO_OUT !== last) flips++;
      last = AUDIO_OUT;
    end
    check(32'(reqs), 32'h0, "no fetch after halt");
    check(32'(flips), 32'h0, "output quiet after halt");
  endtask

  task automatic t_resets;
    int c0;
    @(posedge CLK);
    CPU_RST <= 1'h1;
    @(posedge CLK);
    CPU_RST <= 1'h0;
    c0 = cycles;
    reg_rd(dat_pkg::REG_STATUS);
    check(rd, 32'h03, "flags survive processor reset");
    // counter is internal: let buffer two drain, its stamp must be younger than c0
    reg_wr(dat_pkg::REG_CONTROL, ctl(1'h1, 4'h2, 4'h3));
    wait_irq(1500);
    reg_rd(dat_pkg::REG_DEPARTURE_TIME);
    check(32'(rd < 32'(cycles - c0)), 32'h1, "time counter cleared");
    reg_wr(dat_pkg::REG_CONTROL, 32'h1 << dat_pkg::CT_SELF_RESET);
    reg_rd(dat_pkg::REG_STATUS);
    check(rd, 32'h10, "status after self reset");
    reg_rd(dat_pkg::REG_CONTROL);
    check(rd, 32'h0, "control after self reset");
    reg_rd(dat_pkg::REG_FIRST_START);
    check(rd, 32'h0, "start after self reset");
  endtask

  task automatic t_power;
    @(posedge CLK);
    GLOBAL_POWER_DOWN <= 1'h1;
    @(posedge CLK);
    #1 check(32'(POWERED_DOWN), 32'h1, "sleeps with chip");
    reg_wr(dat_pkg::REG_CONTROL, 32'h1 << dat_pkg::CT_STAY_AWAKE);
    @(posedge CLK);
    #1 check(32'(POWERED_DOWN), 32'h0, "stays awake");
    @(posedge CLK);
    GLOBAL_POWER_DOWN <= 1'h0;
  endtask

  task automatic t_subframes;
    int flips;
    logic last;
    flips = 0;
    reg_wr(dat_pkg::REG_SYNTH_RATE, 32'h80000000);
    reg_wr(dat_pkg::REG_FIRST_START, 32'h1000);
    reg_wr(dat_pkg::REG_SECOND_START, 32'h2000);
    reg_wr(dat_pkg::REG_BUFFER_LENGTH, 32'h40);
    reg_wr(dat_pkg::REG_CONTROL, 32'h1 << dat_pkg::CT_RUN);
    repeat (300) @(posedge CLK);
    last = AUDIO_OUT;
    // bi-phase mark flips at every two-UI data slot edge, i.e. every 4 cycles outside the preamble slots
    repeat (256) begin
      @(posedge CLK);
      if (AUDIO_OUT !== last) flips++;
      last = AUDIO_OUT;
    end
    check(32'(flips >= 60), 32'h1, "slot transitions present");
  endtask

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge CLK);
    RSTN <= 1'h1;
    t_reset_values();
    t_setup();
    t_first_drain();
    t_underrun();
    t_halt();
    t_resets();
    t_power();
    t_subframes();
    wrap_up();
  end
endmodule

`default_nettype wire
